// [logic/typec_port_status_cap_regs.sv]
// Port controller status, fault, command, capability and receive-detect registers
// Notes on behaviour
// - Initialization pending flag always reads 0; device never sets it.
// - Power status bit 3 shows VBUS monitoring on; resets to 1.
// - Power status bit 2 shows VBUS connected while VBUS monitoring is on; it reads 0 when monitoring is off.
// - Power status bit 1 shows Vconn_seen_flag on either CC pin.
// - Fault bit 7 latches a VCONN over-voltage fault.
// - Fault bit 1 latches VCONN over-current or voltage drop with switch closed.
// - Fault bit 0 latches transmit request made with empty transmit buffer.
// - Command 22h turns VBUS detection off, 33h turns it on.
// - Command 88h sets the interface-error fault bit.
// - Command 99h starts dual-role toggling only when dual-role bit is set.
// - Capability bits 7:5 read 110, all roles supported.
// - Capability bit 4 reads 1, all frame types including debug supported.
// - Capability bit 3 reads 1; bits 2:0 read 0.
// - Second capability byte reads 02h: only pull-up levels 10b.
// - Alarm resolution bits 5:4 read 11; threshold capability bits read 0.
// - VCONN power field bits 3:1 reads 010, meaning 2 W.
// - Third capability byte bit 0 reads 1: VCONN over-current detection.
// - Input and output capability registers read all zeros.
// - Header info bits 2:1 hold protocol revision, reset 01.
// - Header info bit 4 cable plug, bit 3 data role, bit 0 power role.
// - Receive-detect bits 6:1 enable their frame types; reset 0.
// - Receive-detect bit 0 enables plain frame detection.
`default_nettype none
module typec_port_status_cap_regs
   import port_regs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire reg_req_t     req,
   output logic      [7:0]   rdata,
   input  wire logic         vbus_attached_flag,
   input  wire logic         vconn_seen_flag,
   input  wire logic         vconn_switch_closed,
   input  wire fault_evt_t   fault_evt,
   input  wire logic         dual_role_toggle_bit,
   output logic              vbus_monitor_on_flag,
   output logic              look_connect_start,
   output rx_enables_t       rx_enables,
   output header_info_t      header_info
);
   // =========================================================================
   // State
   logic         monitor_reg;
   logic         monitor_next;
   logic [7:0]   header_reg;
   logic [7:0]   header_next;
   logic [7:0]   rxdet_reg;
   logic [7:0]   rxdet_next;
   logic [7:0]   rdata_reg;
   logic [7:0]   rdata_next;
   logic         look_reg;
   logic         look_next;
   logic [2:0]   fault_set;
   logic [2:0]   fault_flags;
   logic         fault_clear;
   logic         cmd_wr;
   logic [7:0]   power_status;
   logic [7:0]   fault_status;

   assign cmd_wr = req.wr && (req.addr == OFS_COMMAND);

   // =========================================================================
   // Fault latching; drop counts only while switch is closed
   always_comb
   begin
      fault_set[2] = fault_evt.vconn_ov;
      fault_set[1] = fault_evt.vconn_oc
                     | (fault_evt.vconn_drop & vconn_switch_closed);
      fault_set[0] = fault_evt.tx_req_empty
                     | (cmd_wr && req.wdata == CMD_FORCE_IF_ERR);
      fault_clear  = req.rd && (req.addr == OFS_FAULT_STATUS);
   end

   sticky_flags #(
      .WIDTH     (3)
   ) u_fault_flags (
      .clk       (clk),
      .rstn      (rstn),
      .set_in    (fault_set),
      .clear_all (fault_clear),
      .flags     (fault_flags)
   );

   // =========================================================================
   // Assemble status views; unsupported bits read 0
   always_comb
   begin
      power_status                 = 8'h00;
      power_status[POS_INIT_PEND]  = 1'b0;
      power_status[POS_MONITOR_ON] = monitor_reg;
      power_status[POS_VBUS_ATT]   = vbus_attached_flag & monitor_reg;
      power_status[POS_VCONN_SEEN] = vconn_seen_flag;
      fault_status                 = 8'h00;
      fault_status[POS_VCONN_OV]   = fault_flags[2];
      fault_status[POS_VCONN_OC]   = fault_flags[1];
      fault_status[POS_IF_ERROR]   = fault_flags[0];
   end

   // =========================================================================
   // Writable state and commands; command register itself holds nothing
   always_comb
   begin
      monitor_next = monitor_reg;
      header_next  = header_reg;
      rxdet_next   = rxdet_reg;
      look_next    = 1'b0;
      if (cmd_wr)
      begin
         if (req.wdata == CMD_VBUS_DET_OFF)
            monitor_next = 1'b0;
         else if (req.wdata == CMD_VBUS_DET_ON)
            monitor_next = 1'b1;
         else if (req.wdata == CMD_LOOK_CONNECT)
            look_next = dual_role_toggle_bit;
      end
      if (req.wr && req.addr == OFS_HEADER_INFO)
         header_next = req.wdata & MASK_HEADER_INFO;
      if (req.wr && req.addr == OFS_RX_DETECT)
         rxdet_next = req.wdata & MASK_RX_DETECT;
   end

   // =========================================================================
   // Read mux; data is registered, so it appears one cycle after the read
   always_comb
   begin
      rdata_next = rdata_reg;
      if (req.rd)
      begin
         case (req.addr)
            OFS_POWER_STATUS: rdata_next = power_status;
            OFS_FAULT_STATUS: rdata_next = fault_status;
            OFS_COMMAND:      rdata_next = 8'h00;
            OFS_CAP_BYTE_A:   rdata_next = VAL_CAP_BYTE_A;
            OFS_CAP_BYTE_B:   rdata_next = VAL_CAP_BYTE_B;
            OFS_CAP_BYTE_C:   rdata_next = VAL_CAP_BYTE_C;
            OFS_CAP_BYTE_D:   rdata_next = VAL_CAP_BYTE_D;
            OFS_INPUT_CAP:    rdata_next = VAL_INPUT_CAP;
            OFS_OUTPUT_CAP:   rdata_next = VAL_OUTPUT_CAP;
            OFS_HEADER_INFO:  rdata_next = header_reg;
            OFS_RX_DETECT:    rdata_next = rxdet_reg;
            default:          rdata_next = 8'h00;
         endcase
      end
   end

   // Registering only
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         monitor_reg <= RST_VBUS_MONITOR;
         header_reg  <= RST_HEADER_INFO;
         rxdet_reg   <= RST_RX_DETECT;
         rdata_reg   <= 8'h00;
         look_reg    <= 1'b0;
      end
      else
      begin
         monitor_reg <= monitor_next;
         header_reg  <= header_next;
         rxdet_reg   <= rxdet_next;
         rdata_reg   <= rdata_next;
         look_reg    <= look_next;
      end
   end

   // =========================================================================
   // Outputs
   assign rdata                = rdata_reg;
   assign vbus_monitor_on_flag = monitor_reg;
   assign look_connect_start   = look_reg;
   assign rx_enables           = rxdet_reg[6:0];
   assign header_info          = header_reg[4:0];
endmodule // typec_port_status_cap_regs
`default_nettype wire

// [logic/port_regs_pkg.sv]
// Package: offsets, reset values, field positions and types for the port register bank
`default_nettype none
package port_regs_pkg;
   // =========================================================================
   // Register offsets
   localparam logic [7:0] OFS_POWER_STATUS   = 8'h1E;
   localparam logic [7:0] OFS_FAULT_STATUS   = 8'h1F;
   localparam logic [7:0] OFS_COMMAND        = 8'h23;
   localparam logic [7:0] OFS_CAP_BYTE_A     = 8'h24;
   localparam logic [7:0] OFS_CAP_BYTE_B     = 8'h25;
   localparam logic [7:0] OFS_CAP_BYTE_C     = 8'h26;
   localparam logic [7:0] OFS_CAP_BYTE_D     = 8'h27;
   localparam logic [7:0] OFS_INPUT_CAP      = 8'h28;
   localparam logic [7:0] OFS_OUTPUT_CAP     = 8'h29;
   localparam logic [7:0] OFS_HEADER_INFO    = 8'h2E;
   localparam logic [7:0] OFS_RX_DETECT      = 8'h2F;
   localparam logic [7:0] OFS_INIT_LIMIT     = 8'h0F;

   // =========================================================================
   // Reset and fixed values
   localparam logic [7:0] RST_FAULT_STATUS   = 8'h00;
   localparam logic [7:0] RST_HEADER_INFO    = 8'h02;
   localparam logic [7:0] RST_RX_DETECT      = 8'h00;
   localparam logic       RST_VBUS_MONITOR   = 1'b1;
   localparam logic [7:0] VAL_CAP_BYTE_A     = 8'hD8;
   localparam logic [7:0] VAL_CAP_BYTE_B     = 8'h02;
   localparam logic [7:0] VAL_CAP_BYTE_C     = 8'h35;
   localparam logic [7:0] VAL_CAP_BYTE_D     = 8'h00;
   localparam logic [7:0] VAL_INPUT_CAP      = 8'h00;
   localparam logic [7:0] VAL_OUTPUT_CAP     = 8'h00;

   // =========================================================================
   // Field positions and masks
   localparam int POS_MONITOR_ON   = 3;
   localparam int POS_VBUS_ATT     = 2;
   localparam int POS_VCONN_SEEN   = 1;
   localparam int POS_INIT_PEND    = 6;
   localparam int POS_VCONN_OV     = 7;
   localparam int POS_VCONN_OC     = 1;
   localparam int POS_IF_ERROR     = 0;
   localparam logic [7:0] MASK_HEADER_INFO = 8'h1F;
   localparam logic [7:0] MASK_RX_DETECT   = 8'h7F;

   // =========================================================================
   // Command codes
   localparam logic [7:0] CMD_VBUS_DET_OFF = 8'h22;
   localparam logic [7:0] CMD_VBUS_DET_ON  = 8'h33;
   localparam logic [7:0] CMD_FORCE_IF_ERR = 8'h88;
   localparam logic [7:0] CMD_LOOK_CONNECT = 8'h99;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Fault events from the analog front end and transmitter
   typedef struct packed {
      logic vconn_ov;
      logic vconn_oc;
      logic vconn_drop;
      logic tx_req_empty;
   } fault_evt_t;

   // Receive detect enables, one bit per frame type
   typedef struct packed {
      logic cable_reset;
      logic hard_reset;
      logic detect_dbg_double_prime_en;
      logic detect_dbg_prime_en;
      logic detect_double_prime_en;
      logic detect_prime_en;
      logic detect_plain_frame_en;
   } rx_enables_t;

   // Message header info fields
   typedef struct packed {
      logic       cable_plug;
      logic       data_role_dfp;
      logic [1:0] protocol_revision_code;
      logic       power_role_src;
   } header_info_t;
endpackage
`default_nettype wire

// [logic/sticky_flags.sv]
// Sticky event flags with read-to-clear, set winning over clear
`default_nettype none
module sticky_flags
   import port_regs_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear_all,
   output logic      [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   // =========================================================================
   // Next state per flag
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_flag
         // A new event in the clearing cycle survives the clear
         always_comb
         begin
            flags_next[g] = set_in[g] | (flags_reg[g] & ~clear_all);
         end
      end
   endgenerate

   // Registering only
   always_ff @(posedge clk)
   begin
      if (!rstn)
         flags_reg <= '0;
      else
         flags_reg <= flags_next;
   end

   assign flags = flags_reg;
endmodule // sticky_flags
`default_nettype wire

// [verif/typec_port_status_cap_regs_assertions.sv]
// Checker for the port register bank, bound to its top module
`default_nettype none
module port_regs_checker
   import port_regs_pkg::*;
(
   input wire logic         clk,
   input wire logic         rstn,
   input wire reg_req_t     req,
   input wire logic [7:0]   rdata,
   input wire logic         vbus_attached_flag,
   input wire logic         vconn_seen_flag,
   input wire logic         vconn_switch_closed,
   input wire fault_evt_t   fault_evt,
   input wire logic         dual_role_toggle_bit,
   input wire logic         vbus_monitor_on_flag,
   input wire logic         look_connect_start,
   input wire rx_enables_t  rx_enables,
   input wire header_info_t header_info
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Port relations, all on the one clock
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   start_cmd_a:
   assert property (req.wr && req.addr == 8'h23 && req.wdata == 8'h99 && dual_role_toggle_bit
      |=> look_connect_start ##1 !look_connect_start) else $error("bad start pulse");
   det_off_a:
   assert property (req.wr && req.addr == 8'h23 && req.wdata == 8'h22
      |=> !vbus_monitor_on_flag) else $error("detection not off");
   det_on_a:
   assert property (req.wr && req.addr == 8'h23 && req.wdata == 8'h33
      |=> vbus_monitor_on_flag) else $error("detection not on");
   pwr_read_a:
   assert property (req.rd && req.addr == 8'h1E |=> rdata == {4'h0, $past(vbus_monitor_on_flag),
      $past(vbus_monitor_on_flag) && $past(vbus_attached_flag), $past(vconn_seen_flag), 1'b0})
      else $error("bad power status");
   cap_read_a:
   assert property (req.rd && req.addr == 8'h24 |=> rdata == 8'hD8) else $error("bad caps");
   hdr_wr_a:
   assert property (req.wr && req.addr == 8'h2E
      |=> {3'h0, header_info} == ($past(req.wdata) & 8'h1F)) else $error("bad header info");
   rx_wr_a:
   assert property (req.wr && req.addr == 8'h2F
      |=> {1'b0, rx_enables} == ($past(req.wdata) & 8'h7F)) else $error("bad rx enables");
   ov_latch_a:
   assert property (fault_evt.vconn_ov ##1 (req.rd && req.addr == 8'h1F)
      |=> rdata[7]) else $error("overvoltage lost");
   oc_latch_a:
   assert property ((fault_evt.vconn_oc || fault_evt.vconn_drop && vconn_switch_closed)
      ##1 (req.rd && req.addr == 8'h1F) |=> rdata[1]) else $error("overcurrent lost");
   err_latch_a:
   assert property (fault_evt.tx_req_empty ##1 (req.rd && req.addr == 8'h1F)
      |=> rdata[0]) else $error("interface error lost");
endmodule // port_regs_checker
bind typec_port_status_cap_regs port_regs_checker chk_u (.clk, .rstn, .req, .rdata,
   .vbus_attached_flag, .vconn_seen_flag, .vconn_switch_closed, .fault_evt,
   .dual_role_toggle_bit, .vbus_monitor_on_flag, .look_connect_start, .rx_enables, .header_info);
`default_nettype wire

// [verif/host_model.sv]
// Host processor model: single byte register writes and reads
`default_nettype none
module host_model
   import port_regs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output var  reg_req_t   req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Bus idles until asked; one request cycle each, never back to back
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = {1'b1, 1'b0, a, d};
      @(negedge clk);
      req = '0;
   endtask
   // Data is taken a cycle after the request edge, once settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req = {1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      req = '0;
      d = rdata;
   endtask
endmodule // host_model
`default_nettype wire

// [verif/typec_port_status_cap_regs_test.sv]
// Self-checking bench for the port status, fault, command and capability registers
`default_nettype none
module typec_port_status_cap_regs_test;
   import port_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk;
   logic         rstn;
   reg_req_t     req;
   logic [7:0]   rdata;
   logic [7:0]   got;
   logic         vbus_attached_flag;
   logic         vconn_seen_flag;
   logic         vconn_switch_closed;
   logic         dual_role_toggle_bit;
   logic         vbus_monitor_on_flag;
   logic         look_connect_start;
   fault_evt_t   fault_evt;
   rx_enables_t  rx_enables;
   header_info_t header_info;
   int           mismatches = 0;
   int           checks_done = 0;
   // Rows: address, expected read; the last one is an unmapped hole
   logic [15:0]  rows [12] = '{16'h24D8, 16'h2502, 16'h2635, 16'h2700, 16'h2800, 16'h2900,
                              16'h2300, 16'h2E02, 16'h2F00, 16'h1F00, 16'h1E08, 16'h1000};
   // Rows: switch closed, event bits, expected fault status
   logic [12:0]  evts [5] = '{13'h0880, 13'h0402, 13'h1202, 13'h0200, 13'h0101};
   typec_port_status_cap_regs dut_u (.clk, .rstn, .req, .rdata, .vbus_attached_flag,
      .vconn_seen_flag, .vconn_switch_closed, .fault_evt, .dual_role_toggle_bit,
      .vbus_monitor_on_flag, .look_connect_start, .rx_enables, .header_info);
   host_model host_u (.clk, .rdata, .req);
   // ==========================================
   // Clock at 40 MHz
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Compare and count
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t ns: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, got);
      check(got, e);
   endtask
   task automatic conclude();
      $display("Checks made: %0d, mismatches: %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog, far beyond the hundred or so cycles the tests need
   initial
   begin
      #(25 * 3000);
      mismatches++;
      conclude();
   end
   // Main sequence
   initial
   begin
      {rstn, vbus_attached_flag, vconn_seen_flag, vconn_switch_closed} = 4'h0;
      dual_role_toggle_bit = 1'b0;
      fault_evt = '0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      // Host reads the map right away; init flag must already show done
      foreach (rows[i]) rdchk(rows[i][15:8], rows[i][7:0]);
      check({7'h0, vbus_monitor_on_flag}, 8'h01);
      check({3'h0, header_info}, 8'h02);
      host_u.wr(8'h24, 8'h00);
      rdchk(8'h24, 8'hD8);
      host_u.wr(8'h2E, 8'hFF);
      rdchk(8'h2E, 8'h1F);
      check({3'h0, header_info}, 8'h1F);
      for (int i = 0; i < 7; i++)
      begin
         host_u.wr(8'h2F, 8'h01 << i);
         check({1'b0, rx_enables}, 8'h01 << i);
      end
      // VBUS and VCONN seen, then detection off and on again
      {vbus_attached_flag, vconn_seen_flag} = 2'b11;
      rdchk(8'h1E, 8'h0E);
      host_u.wr(8'h23, 8'h22);
      check({7'h0, vbus_monitor_on_flag}, 8'h00);
      rdchk(8'h1E, 8'h02);
      host_u.wr(8'h23, 8'h33);
      check({7'h0, vbus_monitor_on_flag}, 8'h01);
      rdchk(8'h1E, 8'h0E);
      // Toggling search refused without the dual-role bit
      host_u.wr(8'h23, 8'h99);
      check({7'h0, look_connect_start}, 8'h00);
      dual_role_toggle_bit = 1'b1;
      host_u.wr(8'h23, 8'h99);
      check({7'h0, look_connect_start}, 8'h01);
      @(negedge clk);
      check({7'h0, look_connect_start}, 8'h00);
      host_u.wr(8'h23, 8'h88);
      rdchk(8'h1F, 8'h01);
      rdchk(8'h1F, 8'h00);
      // Event held into the clearing read must survive it
      foreach (evts[i])
      begin
         @(negedge clk);
         {vconn_switch_closed, fault_evt} = evts[i][12:8];
         rdchk(8'h1F, evts[i][7:0]);
         fault_evt = '0;
         rdchk(8'h1F, evts[i][7:0]);
         rdchk(8'h1F, 8'h00);
      end
      // Reset in mid-run restores the header
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      rdchk(8'h2E, 8'h02);
      check({3'h0, header_info}, 8'h02);
      check({1'b0, rx_enables}, 8'h00);
      conclude();
   end
endmodule // typec_port_status_cap_regs_test
`default_nettype wire
